/* design/rsc_pkg.sv */
package rsc_pkg;

  // ------------------------------------------------------------
  // register addresses on the special-function register port
  // ------------------------------------------------------------
  localparam logic [7:0] SUPPLY_MON_ADDR = 8'hff;
  localparam logic [7:0] RESET_CAUSE_ADDR = 8'hef;

  // ------------------------------------------------------------
  // supply monitor control fields
  // ------------------------------------------------------------
  localparam int SM_ENABLE_BIT = 7;
  localparam int SM_RST_LVL_BIT = 6;
  localparam int SM_WARN_LVL_BIT = 5;
  localparam logic SM_ENABLE_RST = 1'b1;

  // ------------------------------------------------------------
  // reset cause register fields
  // ------------------------------------------------------------
  localparam int RC_PIN_BIT = 0;
  localparam int RC_PWR_BIT = 1;
  localparam int RC_CLK_BIT = 2;
  localparam int RC_WDT_BIT = 3;
  localparam int RC_SW_BIT = 4;
  localparam int RC_CMP_BIT = 5;
  localparam int RC_FLASH_BIT = 6;
  localparam int RC_RTC_BIT = 7;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int CLK_LOSS_US = 100;
  localparam int CLK_LOSS_CYC = (SYS_CLK_HZ / 1_000_000) * CLK_LOSS_US;
  localparam int WDT_DIV = 12;
  localparam int WDT_CNT_W = 16;
  localparam logic [WDT_CNT_W-1:0] WDT_LIMIT = 16'hffff;
  localparam int RST_HOLD_CYC = 4;

  // reset cause vector, one bit per source; merged requests can set several
  typedef struct packed {
    logic rtc;
    logic flash;
    logic cmp;
    logic sw;
    logic wdt;
    logic clk;
    logic pwr;
    logic pin;
  } rsc_cause_s;

  // register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rsc_req_s;

  typedef enum logic [1:0] {
    RSC_RUN  = 2'b00,
    RSC_HOLD = 2'b01,
    RSC_EXIT = 2'b10
  } rsc_state_e;

endpackage

/* design/rsc_reset_source_controller.sv */
module rsc_reset_source_controller (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  input  wire rsc_pkg::rsc_req_s reg_req_i,
  output logic [7:0]             reg_rdata_o,
  input  wire logic              pin_reset_n_i,
  input  wire logic              clk_heartbeat_i,
  input  wire logic              supply_above_reset_level_i,
  input  wire logic              supply_above_warning_level_i,
  input  wire logic              comparator_out_i,
  input  wire logic              comparator_wakeup_en_i,
  input  wire logic              low_power_i,
  input  wire logic              wdt_service_i,
  input  wire logic              wdt_disable_i,
  input  wire logic              flash_illegal_wr_i,
  input  wire logic              flash_illegal_fetch_i,
  input  wire logic              flash_secure_block_i,
  input  wire logic              flash_wr_erase_i,
  input  wire logic              rtc_osc_fail_i,
  input  wire logic              rtc_alarm_match_i,
  output logic                   sys_reset_o,
  output logic                   pin_drive_o,
  output logic                   pin_oe_n_o,
  output logic                   wdt_tick_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    rsc_pkg::rsc_state_e         st;
    logic [2:0]                  hold;
    rsc_pkg::rsc_cause_s         pend;
    rsc_pkg::rsc_cause_s         cause;
    logic                        mon_en;
    logic                        mon_sel;
    logic                        clk_en;
    logic                        cmp_sel;
    logic                        rtc_sel;
    logic                        wdt_en;
    logic [3:0]                  div;
    logic [rsc_pkg::WDT_CNT_W-1:0] wdt_cnt;
    logic [11:0]                 loss_cnt;
    logic                        hb_last;
    logic [7:0]                  rdata;
    logic                        drive;
    logic [1:0]                  pin_mask;
  } rsc_state_s;

  rsc_state_s s_q;
  rsc_state_s s_d;

  // ------------------------------------------------------------
  // async levels: pin, heartbeat, supply, warn, comparator, rtc
  // ------------------------------------------------------------
  logic [6:0] raw_async;
  logic [6:0] syn;
  logic       pin_req;
  logic       hb;
  logic       sup_ok;
  logic       warn_ok;
  logic       cmp_low;
  logic       rtc_fail;
  logic       rtc_alarm;

  assign raw_async = {~pin_reset_n_i, clk_heartbeat_i,
                      supply_above_reset_level_i,
                      supply_above_warning_level_i, comparator_out_i,
                      rtc_osc_fail_i, rtc_alarm_match_i};

  // ------------------------------------------------------------
  // synchronise the seven asynchronous levels listed above
  // ------------------------------------------------------------
  rsc_sync #(
    .W (7)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (raw_async),
    .sync_o    (syn)
  );

  assign {pin_req, hb, sup_ok, warn_ok, cmp_low, rtc_fail, rtc_alarm} =
    {syn[6:3], ~syn[2], syn[1:0]};

  // ------------------------------------------------------------
  // supply register read image
  // ------------------------------------------------------------
  function automatic logic [7:0] sm_image(input logic en, input logic ok,
                                          input logic wok);
    logic [7:0] v;
    v = 8'h00;
    v[rsc_pkg::SM_ENABLE_BIT] = en;
    v[rsc_pkg::SM_RST_LVL_BIT] = ok;
    v[rsc_pkg::SM_WARN_LVL_BIT] = wok;
    return v;
  endfunction

  // ------------------------------------------------------------
  // reset cause register read image
  // ------------------------------------------------------------
  // bit 1 shows the monitor selection or a power cause
  function automatic logic [7:0] rc_image(input rsc_pkg::rsc_cause_s c,
                                          input logic sel);
    logic [7:0] v;
    v = 8'h00;
    v[rsc_pkg::RC_PIN_BIT] = c.pin;
    v[rsc_pkg::RC_PWR_BIT] = c.pwr | sel;
    v[rsc_pkg::RC_CLK_BIT] = c.clk;
    v[rsc_pkg::RC_WDT_BIT] = c.wdt;
    v[rsc_pkg::RC_SW_BIT] = c.sw;
    v[rsc_pkg::RC_CMP_BIT] = c.cmp;
    v[rsc_pkg::RC_FLASH_BIT] = c.flash;
    v[rsc_pkg::RC_RTC_BIT] = c.rtc;
    return v;
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  rsc_pkg::rsc_cause_s req;
  logic                wr_sm;
  logic                wr_rc;
  logic                lp;

  always_comb begin
    s_d = s_q;
    lp = low_power_i;
    wr_sm = reg_req_i.wr && reg_req_i.addr == rsc_pkg::SUPPLY_MON_ADDR;
    wr_rc = reg_req_i.wr && reg_req_i.addr == rsc_pkg::RESET_CAUSE_ADDR;
    req = '0;

    // ----------------------------------------------------------
    // divider and watchdog at system clock / 12
    // ----------------------------------------------------------
    s_d.div = (s_q.div == 4'(rsc_pkg::WDT_DIV - 1)) ? 4'h0
                                                     : s_q.div + 4'h1;
    if (s_q.st == rsc_pkg::RSC_RUN && s_q.wdt_en && !lp) begin
      if (wdt_service_i)
        s_d.wdt_cnt = '0;
      else if (s_q.div == 4'h0 && s_q.wdt_cnt != rsc_pkg::WDT_LIMIT)
        s_d.wdt_cnt = s_q.wdt_cnt + 1'b1;
    end
    if (wdt_disable_i)
      s_d.wdt_en = 1'b0;

    // ----------------------------------------------------------
    // clock loss detector counts cycles without heartbeat edge
    // ----------------------------------------------------------
    s_d.hb_last = hb;
    if (hb != s_q.hb_last || !s_q.clk_en || lp)
      s_d.loss_cnt = '0;
    else if (s_q.loss_cnt != 12'(rsc_pkg::CLK_LOSS_CYC))
      s_d.loss_cnt = s_q.loss_cnt + 12'h001;

    // ----------------------------------------------------------
    // request sources
    // ----------------------------------------------------------
    // own pin pull echoes back through the synchroniser, so the
    // pin request is masked while driving and two cycles after
    s_d.pin_mask = {s_q.pin_mask[0], s_q.drive};
    req.pin = pin_req && !s_q.drive &&
              s_q.pin_mask == 2'b00;
    req.pwr = s_q.mon_en && s_q.mon_sel && !sup_ok && !lp;
    req.clk = s_q.loss_cnt == 12'(rsc_pkg::CLK_LOSS_CYC);
    req.wdt = s_q.wdt_en && !lp &&
              s_q.wdt_cnt == rsc_pkg::WDT_LIMIT;
    req.sw = wr_rc && reg_req_i.wdata[rsc_pkg::RC_SW_BIT];
    req.cmp = s_q.cmp_sel && cmp_low &&
              (!lp || comparator_wakeup_en_i);
    req.flash = flash_illegal_wr_i || flash_illegal_fetch_i ||
                flash_secure_block_i ||
                (flash_wr_erase_i && !s_q.mon_en);
    req.rtc = s_q.rtc_sel && (rtc_fail || rtc_alarm);

    // ----------------------------------------------------------
    // register writes while running
    // ----------------------------------------------------------
    if (s_q.st == rsc_pkg::RSC_RUN) begin
      if (wr_sm)
        s_d.mon_en = reg_req_i.wdata[rsc_pkg::SM_ENABLE_BIT];
      if (wr_rc) begin
        s_d.mon_sel = reg_req_i.wdata[rsc_pkg::RC_PWR_BIT];
        s_d.clk_en = reg_req_i.wdata[rsc_pkg::RC_CLK_BIT];
        s_d.cmp_sel = reg_req_i.wdata[rsc_pkg::RC_CMP_BIT];
        s_d.rtc_sel = reg_req_i.wdata[rsc_pkg::RC_RTC_BIT];
      end
    end

    // ----------------------------------------------------------
    // merged reset sequence
    // ----------------------------------------------------------
    unique case (s_q.st)
      rsc_pkg::RSC_RUN: begin
        if (req != '0) begin
          s_d.st = rsc_pkg::RSC_HOLD;
          s_d.pend = req;
          s_d.hold = 3'(rsc_pkg::RST_HOLD_CYC);
        end
      end
      rsc_pkg::RSC_HOLD: begin
        s_d.pend = s_q.pend | req;
        s_d.loss_cnt = '0;
        if (req != '0)
          s_d.hold = 3'(rsc_pkg::RST_HOLD_CYC);
        else if (s_q.hold != 3'h0)
          s_d.hold = s_q.hold - 3'h1;
        else
          s_d.st = rsc_pkg::RSC_EXIT;
      end
      rsc_pkg::RSC_EXIT: begin
        s_d.st = rsc_pkg::RSC_RUN;
        s_d.cause = s_q.pend;
        s_d.pend = '0;
        s_d.wdt_en = 1'b1;
        s_d.wdt_cnt = '0;
        // divider runs on so ticks stay evenly spaced
        if (s_q.pend.pwr) begin
          s_d.mon_en = 1'b1;
          s_d.mon_sel = 1'b1;
          s_d.cause = '0;
          s_d.cause.pwr = 1'b1;
        end
      end
      default: s_d.st = rsc_pkg::RSC_RUN;
    endcase

    // ----------------------------------------------------------
    // power reset drives the pin; internal sources never do
    // ----------------------------------------------------------
    s_d.drive = s_d.st != rsc_pkg::RSC_RUN && s_d.pend.pwr;

    // ----------------------------------------------------------
    // registered read data
    // ----------------------------------------------------------
    s_d.rdata = 8'h00;
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        rsc_pkg::SUPPLY_MON_ADDR:
          s_d.rdata = sm_image(s_q.mon_en, sup_ok, warn_ok);
        rsc_pkg::RESET_CAUSE_ADDR:
          s_d.rdata = rc_image(s_q.cause, s_q.mon_sel);
        default: s_d.rdata = 8'h00;          // unmapped reads give zero
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.st <= rsc_pkg::RSC_HOLD;
      s_q.pend.pwr <= 1'b1;
      s_q.mon_en <= rsc_pkg::SM_ENABLE_RST;
      s_q.mon_sel <= 1'b1;
      s_q.wdt_en <= 1'b1;
      s_q.drive <= 1'b1;
      s_q.pin_mask <= 2'b11;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata_o = s_q.rdata;
  assign sys_reset_o = s_q.st != rsc_pkg::RSC_RUN;
  assign pin_drive_o = 1'b0;
  assign pin_oe_n_o = ~s_q.drive;              // low while pulling pin
  assign wdt_tick_o = s_q.div == 4'h0;

endmodule

/* design/rsc_sync.sv */
// two-stage synchroniser for a vector of asynchronous levels
module rsc_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

/* tb/rsc_ext_model.sv */
module rsc_ext_model (
  input  wire logic sys_clk_i,
  input  wire logic force_low_i,
  input  wire logic beat_en_i,
  input  wire logic pin_oe_n_i,
  input  wire logic pin_drive_i,
  output logic      pin_n_o,
  output logic      beat_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // open-drain pin with pull-up, external circuit may pull it low
  assign pin_n_o = force_low_i ? 1'b0 : (pin_oe_n_i ? 1'b1 : pin_drive_i);
  // clock-alive heartbeat, frozen while disabled
  initial beat_o = 1'b0;
  always @(posedge sys_clk_i) begin
    if (beat_en_i) begin
      beat_o <= ~beat_o;
    end
  end
endmodule

/* tb/rsc_monitor.sv */
module rsc_monitor (
  input wire logic              sys_clk_i,
  input wire logic              rst_n_i,
  input wire rsc_pkg::rsc_req_s reg_req_i,
  input wire logic [7:0]        reg_rdata_o,
  input wire logic              pin_reset_n_i,
  input wire logic              flash_illegal_wr_i,
  input wire logic              flash_illegal_fetch_i,
  input wire logic              flash_secure_block_i,
  input wire logic              sys_reset_o,
  input wire logic              pin_drive_o,
  input wire logic              pin_oe_n_o,
  input wire logic              wdt_tick_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sw_wr;
  logic fl_err;
  logic sm_rd;

  // --------------------------------------------------------------
  // request decode, only outside reset
  // --------------------------------------------------------------
  assign sw_wr = reg_req_i.wr && !sys_reset_o && reg_req_i.wdata[4]
                 && reg_req_i.addr == rsc_pkg::RESET_CAUSE_ADDR;
  assign fl_err = !sys_reset_o && (flash_illegal_wr_i
                  || flash_illegal_fetch_i || flash_secure_block_i);
  assign sm_rd = reg_req_i.rd && !sys_reset_o
                 && reg_req_i.addr == rsc_pkg::SUPPLY_MON_ADDR;

  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // pin value and enable
  property p_drive; pin_drive_o == 1'b0; endproperty
  a_drive: assert property (p_drive) else $error("pin driven high");
  property p_oe; !pin_oe_n_o |-> sys_reset_o; endproperty
  a_oe: assert property (p_oe) else $error("pin pulled in run");
  // reset causes and minimum reset length
  property p_sw; sw_wr |=> sys_reset_o && pin_oe_n_o; endproperty
  a_sw: assert property (p_sw) else $error("no software reset");
  property p_pin;
    $fell(pin_reset_n_i) ##1 !pin_reset_n_i [*3] |-> ##[0:1] sys_reset_o;
  endproperty
  a_pin: assert property (p_pin) else $error("no pin reset");
  property p_flash; fl_err |-> ##[1:2] sys_reset_o; endproperty
  a_flash: assert property (p_flash) else $error("no flash reset");
  property p_hold; $rose(sys_reset_o) |=> sys_reset_o [*3]; endproperty
  a_hold: assert property (p_hold) else $error("reset too short");
  // divider tick and register reads
  property p_tick; wdt_tick_o |=> (!wdt_tick_o || sys_reset_o) [*8]; endproperty
  a_tick: assert property (p_tick) else $error("tick too close");
  property p_rsvd; sm_rd |=> reg_rdata_o[4:0] == 5'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("low bits not zero");
endmodule

bind rsc_reset_source_controller rsc_monitor mon_u (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i),
  .reg_rdata_o(reg_rdata_o), .pin_reset_n_i(pin_reset_n_i),
  .flash_illegal_wr_i(flash_illegal_wr_i),
  .flash_illegal_fetch_i(flash_illegal_fetch_i),
  .flash_secure_block_i(flash_secure_block_i), .sys_reset_o(sys_reset_o),
  .pin_drive_o(pin_drive_o), .pin_oe_n_o(pin_oe_n_o), .wdt_tick_o(wdt_tick_o)
);

/* tb/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic              sys_clk_i = 1'b0;
  logic              rst_n_i = 1'b0;
  rsc_pkg::rsc_req_s req = '0;
  logic [7:0]        rdata, v, r;
  logic              pin_n, beat, sys_rst, pdrv, poe_n, tick;
  logic              warn_ok = 1'b1, cmp_o = 1'b1, cmp_wk = 1'b0, lp = 1'b0;
  logic              force_low = 1'b0, beat_en = 1'b1, osc_f = 1'b0;
  logic              alarm = 1'b0;
  logic [3:0]        fl = 4'h0;
  int                fail_count = 0, n_compared = 0, m_pwr = 1, k;
  int                seed = 32'h41c0;

  always #25 sys_clk_i = ~sys_clk_i;

  rsc_ext_model ext_u (.sys_clk_i(sys_clk_i), .force_low_i(force_low),
    .beat_en_i(beat_en), .pin_oe_n_i(poe_n), .pin_drive_i(pdrv),
    .pin_n_o(pin_n), .beat_o(beat));
  rsc_reset_source_controller dut_u (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .pin_reset_n_i(pin_n), .clk_heartbeat_i(beat),
    .supply_above_reset_level_i(1'b1), .supply_above_warning_level_i(warn_ok),
    .comparator_out_i(cmp_o), .comparator_wakeup_en_i(cmp_wk),
    .low_power_i(lp), .wdt_service_i(1'b0), .wdt_disable_i(1'b0),
    .flash_illegal_wr_i(fl[0]), .flash_illegal_fetch_i(fl[1]),
    .flash_secure_block_i(fl[2]), .flash_wr_erase_i(fl[3]),
    .rtc_osc_fail_i(osc_f), .rtc_alarm_match_i(alarm), .sys_reset_o(sys_rst),
    .pin_drive_o(pdrv), .pin_oe_n_o(poe_n), .wdt_tick_o(tick));

  // ----------------------------------------------------------------
  // model, compare and bus tasks
  // ----------------------------------------------------------------
  function automatic logic [7:0] exp_cause(input int b);
    return 8'(1 << b) | (m_pwr != 0 ? 8'h02 : 8'h00);
  endfunction
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    cyc(1);
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    cyc(1);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    cyc(1);
    req.rd = 1'b0;
    d = rdata;
  endtask
  // bounded wait on reset output or tick
  task automatic wait_lvl(input bit t, input logic val, input int lim,
                          output int n);
    for (n = 0; (t ? tick : sys_rst) !== val; n++) begin
      if (n == lim) begin
        fail_count++;
        $display("Error wait expected %b seen %b", val, !val);
        tally_and_finish();
      end
      cyc(1);
    end
  endtask
  task automatic settle(input string nm, input int b);
    wait_lvl(0, 1'b0, 300, k);
    rd(rsc_pkg::RESET_CAUSE_ADDR, v);
    chk(nm, exp_cause(b), v);
    $display("test %s done", nm);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(20);
    rst_n_i = 1'b1;
    settle("power_on", 1);
    for (int i = 0; i < 4; i++) begin
      r = 8'($random(seed));
      warn_ok = r[5];
      wr(rsc_pkg::SUPPLY_MON_ADDR, {1'b1, r[6:5], 3'h0, r[1:0]});
      cyc(3);
      rd(rsc_pkg::SUPPLY_MON_ADDR, v);
      chk("supply_ctl", {2'b11, warn_ok, 5'h00}, v);
      rd({1'b0, r[6:0]}, v);
      chk("unmapped", 8'h00, v);
    end
    wr(rsc_pkg::RESET_CAUSE_ADDR, 8'h12);
    settle("software", 4);
    wr(rsc_pkg::SUPPLY_MON_ADDR, 8'h00);
    wr(rsc_pkg::RESET_CAUSE_ADDR, 8'h10);
    m_pwr = 0;
    settle("keep_monitor", 4);
    rd(rsc_pkg::SUPPLY_MON_ADDR, v);
    chk("monitor_off", {2'b01, warn_ok, 5'h00}, v);
    for (int i = 3; i >= 0; i--) begin
      cyc(1);
      fl = 4'(1 << i);
      cyc(1);
      fl = 4'h0;
      settle("flash", 6);
      if (i == 3) begin
        wr(rsc_pkg::SUPPLY_MON_ADDR, 8'h80);
        wr(rsc_pkg::RESET_CAUSE_ADDR, 8'h02);
        m_pwr = 1;
      end
    end
    fl = 4'h8;
    cyc(1);
    fl = 4'h0;
    cyc(6);
    chk("flash_ok", 8'h00, {7'h0, sys_rst});
    lp = 1'b1;
    force_low = 1'b1;
    wait_lvl(0, 1'b1, 10, k);
    force_low = 1'b0;
    settle("pin", 0);
    wr(rsc_pkg::RESET_CAUSE_ADDR, 8'h22);
    cmp_o = 1'b0;
    cyc(30);
    chk("cmp_sleep", 8'h00, {7'h0, sys_rst});
    cmp_wk = 1'b1;
    wait_lvl(0, 1'b1, 10, k);
    cmp_o = 1'b1;
    cmp_wk = 1'b0;
    lp = 1'b0;
    settle("comparator", 5);
    for (int i = 0; i < 2; i++) begin
      wr(rsc_pkg::RESET_CAUSE_ADDR, 8'h82);
      lp = i[0];
      {osc_f, alarm} = 2'(1 << i);
      wait_lvl(0, 1'b1, 10, k);
      {osc_f, alarm} = 2'b00;
      lp = 1'b0;
      settle("rtc", 7);
    end
    for (int i = 0; i < 2; i++) begin
      wr(rsc_pkg::RESET_CAUSE_ADDR, 8'h06);
      lp = 1'b1;
      beat_en = 1'b0;
      cyc(rsc_pkg::CLK_LOSS_CYC + 100);
      chk("loss_sleep", 8'h00, {7'h0, sys_rst});
      beat_en = 1'b1;
      cyc(4);
      lp = 1'b0;
      cyc(4);
      beat_en = 1'b0;
      wait_lvl(0, 1'b1, rsc_pkg::CLK_LOSS_CYC + 100, k);
      beat_en = 1'b1;
      chk("loss_time", 8'h01, {7'h0, k > rsc_pkg::CLK_LOSS_CYC - 10
          && k < rsc_pkg::CLK_LOSS_CYC + 10});
      settle("clock_loss", 2);
    end
    wr(rsc_pkg::RESET_CAUSE_ADDR, 8'h02);
    wait_lvl(1, 1'b1, 40, k);
    cyc(1);
    wait_lvl(1, 1'b1, 40, k);
    chk("tick_gap", 8'(rsc_pkg::WDT_DIV), 8'(k + 1));
    $display("test tick done");
    tally_and_finish();
  end
endmodule
